// file: rtl/sdc_pkg.sv
package sdc_pkg;

  // delay line shape: one tap per ref_clk cycle
  localparam int unsigned TAP_W      = 8;
  localparam int unsigned LINE_DEPTH = 256;
  localparam logic [7:0]  TAP_MAX    = 8'hFF;

  // input fifo pointers
  localparam int unsigned PTR_W     = 3;
  localparam logic [2:0]  PTR_RESET = 3'h0;
  localparam logic [2:0]  PTR_ONE   = 3'h1;

  // margin offset, centred so both directions have room
  localparam int unsigned MARGIN_W       = 6;
  localparam logic [5:0]  MARGIN_DEFAULT = 6'h20;
  localparam logic [5:0]  MARGIN_MAX     = 6'h3F;
  localparam logic [5:0]  MARGIN_MIN     = 6'h00;
  localparam logic [5:0]  MARGIN_ONE     = 6'h01;

  // read window stays open this many cycles after the last request
  localparam logic [7:0] RD_TAIL_CYC = 8'h10;

  // register map (byte addresses)
  localparam int unsigned AXI_AW     = 4;
  localparam logic [3:0]  OFS_STATUS = 4'h0;
  localparam logic [3:0]  OFS_MASK   = 4'h4;
  localparam logic [3:0]  OFS_STATE  = 4'h8;

  // status / mask bit positions
  localparam int unsigned EV_RX_MAX  = 0;
  localparam int unsigned EV_TX_MAX  = 1;
  localparam int unsigned EV_BURST   = 2;
  localparam int unsigned EV_DATA_OK = 3;
  localparam int unsigned EV_W       = 4;
  localparam logic [3:0]  EV_RESET   = 4'h0;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: rtl/sdc_strobe_delay_ctrl.sv
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Function
// - the memory strobe is shifted through a slave delay line steered by the dll code before capture.
// - the read capture strobe is the strobe delayed by the quarter-period code from the dll.
// - two write clocks are made, one for the strobe and one 90 degrees later for the data.
// - a separate leveling delay is set by the eight-bit level delay setting input.
// - core logic shifts read and write delays at run time through load, step and direction inputs.
// - a read flag and a write flag show when the respective margin offset is at its maximum.
// - three-bit in and out pointers for the input fifo move data from strobe to edge clock.
// - a data-ok pulse marks the start of valid read data and a burst indicator is given.
// - one pointer pair serves every input cell of the strobe group.
module sdc_strobe_delay_ctrl (
  input  wire logic                      ref_clk,
  input  wire logic                      srst,
  input  wire logic                      mem_strobe,
  input  wire logic                      edge_io_clock,
  input  wire logic [1:0]                read_req,
  input  wire logic [1:0]                fetch_pulse_select,
  input  wire logic [sdc_pkg::TAP_W-1:0] strobe_delay_code,
  input  wire logic                      rx_margin_load_n,
  input  wire logic                      rx_margin_step,
  input  wire logic                      rx_margin_dir,
  input  wire logic                      tx_margin_load_n,
  input  wire logic                      tx_margin_step,
  input  wire logic                      tx_margin_dir,
  input  wire logic                      tx_pause,
  input  wire logic [sdc_pkg::TAP_W-1:0] level_delay_setting,
  output logic                           rx_capture_strobe,
  output logic                           tx_strobe_clock,
  output logic                           tx_data_clock,
  output logic [sdc_pkg::PTR_W-1:0]      fifo_in_pointer,
  output logic [sdc_pkg::PTR_W-1:0]      fifo_out_pointer,
  output logic                           rx_data_ok,
  output logic                           burst_seen,
  output logic                           rx_margin_at_max,
  output logic                           tx_margin_at_max,
  output logic                           irq,
  input  wire logic [sdc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [sdc_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);
  import sdc_pkg::*;

  // clamp base + code + (margin - default) into the line
  function automatic logic [TAP_W-1:0] tap_of(input logic [TAP_W-1:0]    base,
                                              input logic [TAP_W-1:0]    code,
                                              input logic [MARGIN_W-1:0] m);
    logic [TAP_W+1:0] s;
    s = {2'h0, base} + {2'h0, code} + {4'h0, m};
    if (s < {4'h0, MARGIN_DEFAULT}) begin
      s = 10'h000;
    end else begin
      s = s - {4'h0, MARGIN_DEFAULT};
    end
    if (s > {2'h0, TAP_MAX}) begin
      s = {2'h0, TAP_MAX};
    end
    return s[TAP_W-1:0];
  endfunction

  // pin synchronisers; logic reads only the second stage
  // the first stage may go metastable, so nothing else looks at it
  logic [1:0]            strb_sync;
  logic [1:0]            eck_sync;
  logic [LINE_DEPTH-1:0] rx_line;
  logic [LINE_DEPTH-1:0] tx_line;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      strb_sync <= 2'h0;
      eck_sync  <= 2'h0;
    end else begin
      strb_sync <= {strb_sync[0], mem_strobe};
      eck_sync  <= {eck_sync[0], edge_io_clock};
    end
  end

  // delay lines: tap n is the input n+1 cycles ago
  // one tap per cycle keeps the line exact but limits resolution to ref_clk
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_line <= '0;
      tx_line <= '0;
    end else begin
      rx_line <= {rx_line[LINE_DEPTH-2:0], strb_sync[1]};
      tx_line <= {tx_line[LINE_DEPTH-2:0], eck_sync[1]};
    end
  end

  // margin controls, read side at index 0, write side at index 1
  wire [1:0] m_load_n = {tx_margin_load_n, rx_margin_load_n};
  wire [1:0] m_step   = {tx_margin_step, rx_margin_step};
  wire [1:0] m_dir    = {tx_margin_dir, rx_margin_dir};
  logic [MARGIN_W-1:0] margin [2];
  logic                step_q [2];
  wire  [1:0]          at_max;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_margin
      // step acts on its rising edge so a held level moves only once
      wire step_rise = m_step[g] & ~step_q[g];
      assign at_max[g] = (margin[g] == MARGIN_MAX);
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          margin[g] <= MARGIN_DEFAULT;
          step_q[g] <= 1'b0;
        end else begin
          step_q[g] <= m_step[g];
          if (!m_load_n[g]) begin
            margin[g] <= MARGIN_DEFAULT;
          end else if (step_rise && m_dir[g] && margin[g] != MARGIN_MAX) begin
            margin[g] <= margin[g] + MARGIN_ONE;
          end else if (step_rise && !m_dir[g] && margin[g] != MARGIN_MIN) begin
            margin[g] <= margin[g] - MARGIN_ONE;
          end
        end
      end
    end
  endgenerate

  // tap selection
  // the strobe clock carries leveling only; the data clock adds the quarter code
  wire [TAP_W-1:0] rx_tap  = tap_of(8'h00, strobe_delay_code, margin[0]);
  wire [TAP_W-1:0] tx_tap  = tap_of(level_delay_setting, strobe_delay_code, margin[1]);
  wire             rx_next = rx_line[rx_tap];

  // read capture strobe, never paused: reads must keep flowing
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_capture_strobe <= 1'b0;
    end else begin
      rx_capture_strobe <= rx_next;
    end
  end

  // write clocks freeze while paused so no runt edge reaches the pins
  // the lines keep running, so release resumes at the live phase
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_strobe_clock <= 1'b0;
      tx_data_clock   <= 1'b0;
    end else if (!tx_pause) begin
      tx_strobe_clock <= tx_line[level_delay_setting];
      tx_data_clock   <= tx_line[tx_tap];
    end
  end

  // margin flags
  // one cycle behind the margin so that they come from flip-flops
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_margin_at_max <= 1'b0;
      tx_margin_at_max <= 1'b0;
    end else begin
      rx_margin_at_max <= at_max[0];
      tx_margin_at_max <= at_max[1];
    end
  end

  // read window opened by any request, closes after a tail
  // a request held across the tail keeps reloading, so long reads stay open
  logic [7:0] win_cnt;
  wire        rd_active = (win_cnt != 8'h00);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      win_cnt <= 8'h00;
    end else if (read_req != 2'h0) begin
      win_cnt <= RD_TAIL_CYC;
    end else if (rd_active) begin
      win_cnt <= win_cnt - 8'h01;
    end
  end

  // fifo pointers: in moves on each capture edge inside the read window, out on edge clock rise
  wire             cap_edge = rd_active & (rx_next != rx_capture_strobe);
  wire             eck_rise = tx_line[0] & ~tx_line[1];
  wire [PTR_W-1:0] occ      = fifo_in_pointer - fifo_out_pointer;
  // pulse select sets how many entries lead the reader
  // limitation: eight entries, so occupancy beyond seven aliases
  wire             pop      = eck_rise & (occ > {1'b0, fetch_pulse_select});
  logic            data_started;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fifo_in_pointer  <= PTR_RESET;
      fifo_out_pointer <= PTR_RESET;
    end else begin
      if (cap_edge) begin
        fifo_in_pointer <= fifo_in_pointer + PTR_ONE;
      end
      if (pop) begin
        fifo_out_pointer <= fifo_out_pointer + PTR_ONE;
      end
    end
  end

  // a pop after the window has closed belongs to no read, so it raises no pulse
  wire             first_pop = rd_active & pop & ~data_started;

  // data ok on first pop of a window; burst seen from the first edge until the window closes
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      data_started <= 1'b0;
      rx_data_ok   <= 1'b0;
      burst_seen   <= 1'b0;
    end else begin
      data_started <= rd_active & (data_started | pop);
      rx_data_ok   <= first_pop;
      burst_seen   <= rd_active & (burst_seen | cap_edge);
    end
  end

  // event capture, set wins over a same-cycle clear
  // each event is the edge of its condition, so a held level sets once
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;
  wire  [EV_W-1:0] ev_set;
  wire  [EV_W-1:0] ev_clr;

  assign ev_set[EV_RX_MAX]  = at_max[0] & ~rx_margin_at_max;
  assign ev_set[EV_TX_MAX]  = at_max[1] & ~tx_margin_at_max;
  assign ev_set[EV_BURST]   = rd_active & cap_edge & ~burst_seen;
  assign ev_set[EV_DATA_OK] = first_pop;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status <= EV_RESET;
      irq    <= 1'b0;
    end else begin
      status <= (status & ~ev_clr) | ev_set;
      irq    <= |(status & mask);
    end
  end

  // axi write channel: address and data held until both present
  // a write with lane 0 off is answered but changes nothing
  logic              aw_held;
  logic              w_held;
  logic [AXI_AW-1:0] aw_addr;
  logic [31:0]       w_data;
  logic              w_lane0;
  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire wr_fire  = aw_held & w_held & ~s_axi_bvalid;
  wire next_aw_held = (aw_held | aw_take) & ~wr_fire;
  wire next_w_held  = (w_held | w_take) & ~wr_fire;
  wire next_bvalid  = wr_fire | (s_axi_bvalid & ~s_axi_bready);
  wire wr_status    = wr_fire & w_lane0 & (aw_addr == OFS_STATUS);
  wire wr_mask      = wr_fire & w_lane0 & (aw_addr == OFS_MASK);
  wire wr_mapped    = (aw_addr == OFS_STATUS) | (aw_addr == OFS_MASK) |
                      (aw_addr == OFS_STATE);

  assign ev_clr = wr_status ? w_data[EV_W-1:0] : EV_RESET;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0000_0000;
      w_lane0 <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data  <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end
    end
  end

  // write response and mask register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      mask          <= EV_RESET;
    end else begin
      s_axi_awready <= ~next_aw_held & ~next_bvalid;
      s_axi_wready  <= ~next_w_held & ~next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (wr_fire) begin
        s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (wr_mask) begin
        mask <= w_data[EV_W-1:0];
      end
    end
  end

  // read channel: answer one cycle after the address is taken
  // unmapped reads answer slverr with zero data
  wire        ar_take     = s_axi_arvalid & s_axi_arready;
  wire        next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire [31:0] state_word  = {12'h000, margin[1], margin[0], 2'h0,
                             fifo_out_pointer, fifo_in_pointer};
  wire        rd_mapped   = (s_axi_araddr == OFS_STATUS) | (s_axi_araddr == OFS_MASK) |
                            (s_axi_araddr == OFS_STATE);
  wire [31:0] rd_word     = (s_axi_araddr == OFS_STATUS) ? {28'h0, status} :
                            (s_axi_araddr == OFS_MASK)   ? {28'h0, mask}   :
                            (s_axi_araddr == OFS_STATE)  ? state_word      :
                                                           32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

endmodule

// file: testbench/sdc_strobe_delay_ctrl_assertions.sv
`timescale 1ns/1ps
// pin-level watcher for the strobe delay block
module sdc_strobe_delay_ctrl_checker (
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic [1:0] read_req,
  input wire logic       rx_margin_load_n,
  input wire logic       tx_margin_load_n,
  input wire logic       tx_pause,
  input wire logic       tx_strobe_clock,
  input wire logic       tx_data_clock,
  input wire logic [2:0] fifo_in_pointer,
  input wire logic [2:0] fifo_out_pointer,
  input wire logic       rx_data_ok,
  input wire logic       burst_seen,
  input wire logic       rx_margin_at_max,
  input wire logic       tx_margin_at_max,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [4:0] idle_cnt;
  // cycles since last read request, saturating so it never wraps
  always_ff @(posedge ref_clk) begin
    if (srst || read_req != 2'h0) idle_cnt <= 5'h00;
    else if (idle_cnt != 5'h1F) idle_cnt <= idle_cnt + 5'h01;
  end
  a_rx_load_default: assert property (!rx_margin_load_n [*3] |-> !rx_margin_at_max)
    else $error("rx flag high while loading default");
  a_tx_load_default: assert property (!tx_margin_load_n [*3] |-> !tx_margin_at_max)
    else $error("tx flag high while loading default");
  a_pause_freezes_tx: assert property (tx_pause [*2] |=>
    $stable(tx_strobe_clock) && $stable(tx_data_clock)) else $error("tx clock moved in pause");
  a_in_ptr_step: assert property ($changed(fifo_in_pointer) |->
    fifo_in_pointer == 3'($past(fifo_in_pointer) + 3'h1)) else $error("in pointer jumped");
  a_out_ptr_step: assert property ($changed(fifo_out_pointer) |->
    fifo_out_pointer == 3'($past(fifo_out_pointer) + 3'h1)) else $error("out pointer jumped");
  a_out_needs_data: assert property ($changed(fifo_out_pointer) |->
    $past(fifo_in_pointer) != $past(fifo_out_pointer)) else $error("out pointer passed in");
  a_idle_no_capture: assert property (idle_cnt > 5'h14 |=> $stable(fifo_in_pointer))
    else $error("capture outside read window");
  a_data_ok_pulse: assert property (rx_data_ok |=> !rx_data_ok)
    else $error("data ok longer than one cycle");
  a_data_ok_burst: assert property (rx_data_ok |-> burst_seen)
    else $error("data ok without burst");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule
bind sdc_strobe_delay_ctrl sdc_strobe_delay_ctrl_checker i_sdc_strobe_delay_ctrl_checker (
  .ref_clk, .srst, .read_req, .rx_margin_load_n, .tx_margin_load_n, .tx_pause,
  .tx_strobe_clock, .tx_data_clock, .fifo_in_pointer, .fifo_out_pointer, .rx_data_ok,
  .burst_seen, .rx_margin_at_max, .tx_margin_at_max, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid);

// file: testbench/sdc_mem_model.sv
`timescale 1ns/1ps
// memory side: a strobe burst of n edges, one edge per half memory clock
module sdc_mem_model #(parameter int HALF_NS = 160) (
  input wire logic       go,
  input wire logic [3:0] n_edges,
  output logic           mem_strobe
);
  // strobe parks low between bursts, as terminated, so even counts only
  initial mem_strobe = 1'b0;
  always @(posedge go) begin
    #2; // off the sampling edge, so each edge lands in one known cycle
    repeat (n_edges) #(HALF_NS) mem_strobe = ~mem_strobe;
  end
endmodule

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import sdc_pkg::*;
  logic ref_clk = 1'b0, edge_io_clock = 1'b0, srst = 1'b1, go = 1'b0, tx_pause = 1'b0;
  logic m_load_n = 1'b1, m_step = 1'b0, m_dir = 1'b1, irq, burst_seen, rx_data_ok;
  logic [1:0] read_req = 2'h0, fetch_pulse_select = 2'h0, s_axi_bresp, s_axi_rresp;
  logic [3:0] n_edges = 4'h0, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, mem_strobe, rx_capture_strobe, tx_strobe_clock, tx_data_clock;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, st;
  logic [2:0]  fifo_in_pointer, fifo_out_pointer, in_e = 3'h0, out_e = 3'h0;
  logic [15:0] hist = 16'h0;
  logic [7:0]  ms_hist = 8'h00;
  logic        rx_max, tx_max, v;
  int          err_count = 0, checks = 0, ok_cnt = 0, bs_cnt = 0;
  always #20 ref_clk = ~ref_clk;
  always #160 edge_io_clock = ~edge_io_clock;
  // strobe clock and pin histories, data-ok pulses and burst starts seen
  always @(posedge ref_clk) begin
    hist <= {hist[14:0], tx_strobe_clock};
    if (rx_data_ok === 1'b1) ok_cnt++;
    ms_hist <= {ms_hist[6:0], mem_strobe};
  end
  always @(posedge burst_seen) bs_cnt++;
  sdc_mem_model i_sdc_mem_model (.go, .n_edges, .mem_strobe);
  // quarter code: 2 taps is 90 degrees of the 8-cycle edge clock period
  sdc_strobe_delay_ctrl i_sdc_strobe_delay_ctrl (.ref_clk, .srst, .mem_strobe, .edge_io_clock,
    .read_req, .fetch_pulse_select, .strobe_delay_code(8'h02), .level_delay_setting(8'h04),
    .rx_margin_load_n(m_load_n), .rx_margin_step(m_step), .rx_margin_dir(m_dir),
    .tx_margin_load_n(m_load_n), .tx_margin_step(m_step), .tx_margin_dir(m_dir), .tx_pause,
    .rx_capture_strobe, .tx_strobe_clock, .tx_data_clock, .fifo_in_pointer, .fifo_out_pointer,
    .rx_data_ok, .burst_seen, .rx_margin_at_max(rx_max), .tx_margin_at_max(tx_max), .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one register access; a read compares against d
  task automatic acc(input bit wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(wr ? s_axi_bvalid : s_axi_rvalid));
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    chk("resp", {30'h0, wr ? s_axi_bresp : s_axi_rresp}, {30'h0, er});
    if (!wr) chk("rdata", s_axi_rdata, d);
  endtask
  task automatic steps(input logic dir, input int n);
    @(posedge ref_clk);
    m_dir <= dir;
    repeat (n) begin
      @(posedge ref_clk);
      m_step <= 1'b1;
      @(posedge ref_clk);
      m_step <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic burst(input logic [1:0] rq, input logic [3:0] n);
    @(posedge ref_clk);
    read_req <= rq;
    n_edges <= n;
    @(posedge ref_clk);
    go <= 1'b1;
    repeat (n * 4 + 4) @(posedge ref_clk);
    go <= 1'b0;
    read_req <= 2'h0;
  endtask
  task automatic state(input logic [5:0] m);
    acc(0, OFS_STATE, {12'h0, m, m, 2'h0, out_e, in_e}, RESP_OKAY);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    acc(0, OFS_MASK, 32'h0, RESP_OKAY);
    state(MARGIN_DEFAULT);
    acc(0, 4'hC, 32'h0, RESP_SLVERR);
    acc(1, 4'hC, 32'h5, RESP_SLVERR);
    // request codes 1 to 3, pulse select 0..3, occupancy left behind = select
    for (int i = 1; i < 5; i++) begin
      fetch_pulse_select <= 2'(i - 1);
      burst(2'((i - 1) % 3 + 1), 4'h4);
      in_e = in_e + 3'h4;
      out_e = in_e - 3'(i - 1);
      for (int k = 0; k < 200 && fifo_out_pointer !== out_e; k++) @(posedge ref_clk);
      repeat (30) @(posedge ref_clk);
      chk("in ptr", {29'h0, fifo_in_pointer}, {29'h0, in_e});
      chk("out ptr", {29'h0, fifo_out_pointer}, {29'h0, out_e});
    end
    chk("data ok", ok_cnt, 4);
    chk("bursts", bs_cnt, 4);
    // no request: the capture strobe still follows the pin, pointers hold
    fork
      burst(2'h0, 4'h4);
      for (int k = 0; k < 30; k++) begin
        @(posedge ref_clk);
        chk("rx strobe", {31'h0, rx_capture_strobe}, {31'h0, ms_hist[5]});
      end
    join
    state(MARGIN_DEFAULT);
    acc(0, OFS_STATUS, 32'hC, RESP_OKAY);
    chk("irq masked", {31'h0, irq}, 32'h0);
    acc(1, OFS_MASK, 32'h4, RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    chk("irq", {31'h0, irq}, 32'h1);
    acc(1, OFS_STATUS, 32'hC, RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    chk("irq clr", {31'h0, irq}, 32'h0);
    acc(0, OFS_STATUS, 32'h0, RESP_OKAY);
    acc(1, OFS_MASK, 32'h3, RESP_OKAY);
    steps(1'b1, 32);
    chk("max flags", {30'h0, rx_max, tx_max}, 32'h3);
    state(MARGIN_MAX);
    chk("irq max", {31'h0, irq}, 32'h1);
    @(posedge ref_clk);
    m_load_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    m_load_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    state(MARGIN_DEFAULT);
    acc(1, OFS_STATUS, 32'h3, RESP_OKAY);
    steps(1'b0, 40);
    state(MARGIN_MIN);
    chk("low flags", {30'h0, rx_max, tx_max}, 32'h0);
    m_load_n <= 1'b0;
    repeat (40) @(posedge ref_clk);
    m_load_n <= 1'b1;
    // data clock trails strobe clock by the code (2 taps) at default margin
    for (int k = 0; k < 40; k++) begin
      @(posedge ref_clk);
      chk("phase", {31'h0, tx_data_clock}, {31'h0, hist[1]});
    end
    tx_pause <= 1'b1;
    repeat (3) @(posedge ref_clk);
    v = tx_strobe_clock;
    repeat (40) @(posedge ref_clk);
    chk("pause", {31'h0, tx_strobe_clock}, {31'h0, v});
    tx_pause <= 1'b0;
    tally_and_finish();
  end
endmodule
